/* File: hdl/aprr_top.sv */
// aprr_top: conversion control and parallel result readout of a 16-bit converter
// assumes host strobes synchronous to clk; sample words arrive on a valid/ready stream
//
// Operation
// (R01) conversion timed by internal clock, done within 650 ns for 1 MHz throughput
// (R02) input sampled at conversion start, held isolated until conversion ends
// (R03) result bus driven only while chip select and read both low
// (R04) host makes no read 50 ns before to 40 ns after start falling edge
// (R05) byte select high moves low result bits onto upper bus half
// (R06) result code two's complement: 7fff near full scale, 0000 at zero
// (R07) host may use busy falling edge as result-ready interrupt
// (R08) start falling edge raises busy; busy falls when result becomes readable; code raises busy only when idle with a sample in the fifo
// (R09) byte select high: bits 7..0 on lines 15..8, ones on lines 7..0
// (R10) start strobe active low, independent of chip select
// (R11) last completed result held until next conversion completes
`timescale 1ns/1ns
module aprr_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        conversion_start_n,
  input  wire aprr_pkg::aprr_rd_s          rd_in,
  input  wire logic                        sample_valid,
  output logic                             sample_ready,
  input  wire logic [aprr_pkg::RES_W-1:0]  sample_data,
  output logic                             busy,
  output logic                             isolate,
  output logic      [aprr_pkg::RES_W-1:0]  result_bus,
  output logic      [aprr_pkg::RES_W-1:0]  result_bus_oe
);
  aprr_pkg::aprr_state_e            state_q;
  logic                             start_n_q;
  logic                             start_fall;
  logic [aprr_pkg::CNT_W-1:0]       cnt_q;
  logic [aprr_pkg::RES_W-1:0]       held_q;
  logic [aprr_pkg::RES_W-1:0]       result_q;
  logic                             f_valid;
  logic                             f_ready;
  logic [aprr_pkg::RES_W-1:0]       f_data;
  logic                             conv_done;
  logic                             take;
  logic                             rd_act;
  logic [aprr_pkg::CNT_W-1:0]       busy_len_q;
  localparam int                    CONV_DLY = aprr_pkg::CONV_CYCLES;
  localparam logic [aprr_pkg::CNT_W-1:0] CONV_LEN = aprr_pkg::CONV_CYCLES[aprr_pkg::CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  aprr_fifo #(
    .WIDTH (aprr_pkg::RES_W),
    .DEPTH (aprr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start edge detect, independent of chip select
  always_ff @(posedge clk) begin
    if (rst) begin
      start_n_q <= 1'b1;
    end else begin
      start_n_q <= conversion_start_n;
    end
  end
  assign start_fall = start_n_q && !conversion_start_n; // [R10]
  assign conv_done  = (state_q == aprr_pkg::APRR_CONV) && (cnt_q == aprr_pkg::CNT_LAST);
  // fifo drains only at a sample instant, so it stalls otherwise
  assign take       = start_fall && (state_q == aprr_pkg::APRR_IDLE) && f_valid;
  assign f_ready    = take; // [R02]

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= aprr_pkg::APRR_IDLE;
    end else begin
      unique case (state_q)
        aprr_pkg::APRR_IDLE: begin
          if (take) begin
            state_q <= aprr_pkg::APRR_CONV; // [R08]
          end
        end
        aprr_pkg::APRR_CONV: begin
          if (conv_done) begin
            state_q <= aprr_pkg::APRR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_q != aprr_pkg::APRR_CONV) begin
      cnt_q <= aprr_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_q + 1'b1; // [R01]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      held_q <= aprr_pkg::RES_RST;
    end else if (take) begin
      held_q <= f_data; // [R02]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      isolate <= 1'b0;
    end else begin
      busy    <= take || (busy && !conv_done); // [R08]
      isolate <= take || (isolate && !conv_done); // [R02]
    end
  end

  // length of the current busy span, checked against the conversion time
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_len_q <= aprr_pkg::CNT_ZERO;
    end else begin
      busy_len_q <= busy_len_q + 1'b1;
    end
  end

  // code passes through unchanged: two's complement [R06]
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= aprr_pkg::RES_RST;
    end else if (conv_done) begin
      result_q <= held_q; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rd_act = !rd_in.cs_n && !rd_in.rd_n;

  always_ff @(posedge clk) begin
    if (rst) begin
      result_bus_oe <= '0;
    end else begin
      result_bus_oe <= {aprr_pkg::RES_W{rd_act}}; // [R03]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_bus <= aprr_pkg::RES_RST;
    end else if (rd_in.byte_sel) begin
      result_bus <= {result_q[aprr_pkg::BYTE_W-1:0], aprr_pkg::LOW_FILL}; // [R05] [R09]
    end else begin
      result_bus <= result_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing
  a_busy_span: assert property (@(posedge clk) disable iff (rst) // [R01]
    $fell(busy) |-> busy_len_q == CONV_LEN)
    else $error("busy span not one conversion time");
  a_busy_len: assert property (@(posedge clk) disable iff (rst) // [R01]
    $rose(busy) |-> ##CONV_DLY !busy)
    else $error("conversion time wrong");
  a_busy_hold: assert property (@(posedge clk) disable iff (rst) // [R08]
    busy && !conv_done |=> busy)
    else $error("busy dropped before conversion end");
  a_start_busy: assert property (@(posedge clk) disable iff (rst) // [R08]
    take |=> busy && isolate)
    else $error("busy not raised on start");
  a_start_idle: assert property (@(posedge clk) disable iff (rst) // [R08]
    take |-> !busy)
    else $error("start taken while converting");
  a_start_empty: assert property (@(posedge clk) disable iff (rst) // [R08]
    start_fall && !f_valid && !busy |=> !busy)
    else $error("start taken with no sample");
  a_refuse_busy: assert property (@(posedge clk) disable iff (rst) // [R08]
    start_fall && busy |=> $stable(held_q))
    else $error("sample replaced by start while busy");
  a_done_idle: assert property (@(posedge clk) disable iff (rst) // [R08]
    conv_done |=> !busy && !isolate)
    else $error("busy not lowered at conversion end");
  a_isolate: assert property (@(posedge clk) disable iff (rst) // [R02]
    busy |-> isolate && ($rose(busy) || $stable(held_q)))
    else $error("input not isolated");

  // readout
  a_result_upd: assert property (@(posedge clk) disable iff (rst) // [R11]
    $fell(busy) |-> result_q == $past(held_q))
    else $error("result not loaded at end");
  a_result_hold: assert property (@(posedge clk) disable iff (rst) // [R11]
    busy && !conv_done |=> $stable(result_q))
    else $error("result changed mid conversion");
  a_bus_drive: assert property (@(posedge clk) disable iff (rst) // [R03]
    result_bus_oe != '0 |-> $past(rd_act))
    else $error("bus driven without read");
  a_bus_float: assert property (@(posedge clk) disable iff (rst) // [R03]
    !rd_act |=> result_bus_oe == '0)
    else $error("bus not released");
  a_bus_on: assert property (@(posedge clk) disable iff (rst) // [R03]
    rd_act |=> result_bus_oe == '1)
    else $error("bus not driven on read");
  a_oe_same: assert property (@(posedge clk) disable iff (rst) // [R03]
    result_bus_oe == '0 || result_bus_oe == '1)
    else $error("bus lines enabled apart");
  a_byte_high: assert property (@(posedge clk) disable iff (rst) // [R09]
    rd_in.byte_sel |=> result_bus ==
      {$past(result_q[aprr_pkg::BYTE_W-1:0]), aprr_pkg::LOW_FILL})
    else $error("byte mode data wrong");
  a_word_mode: assert property (@(posedge clk) disable iff (rst) // [R05]
    !rd_in.byte_sel |=> result_bus == $past(result_q))
    else $error("word mode data wrong");

  // main scenarios
  c_conv: cover property (@(posedge clk) disable iff (rst) $fell(busy));
  c_byte: cover property (@(posedge clk) disable iff (rst) rd_act && rd_in.byte_sel);
  c_full: cover property (@(posedge clk) disable iff (rst) !sample_ready);
  c_refused: cover property (@(posedge clk) disable iff (rst) start_fall && busy);
  c_empty: cover property (@(posedge clk) disable iff (rst) start_fall && !f_valid && !busy);
endmodule // aprr_top

/* File: hdl/aprr_pkg.sv */
// aprr_pkg: constants and carrier types for the parallel result readout block
// assumes a 100 MHz clock; shared by the top module, the host model and the bench
package aprr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS  = 650;
  // longest time: round down, at least one cycle
  localparam int unsigned CONV_CYCLES   = (CONV_TIME_NS / CLK_PERIOD_NS) > 0 ?
                                          (CONV_TIME_NS / CLK_PERIOD_NS) : 1;
  localparam int unsigned CNT_W         = 7;
  localparam int unsigned RES_W         = 16;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam logic [BYTE_W-1:0] LOW_FILL = 8'hff;
  localparam logic [RES_W-1:0]  RES_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0]  CNT_ZERO = 7'h00;

  typedef enum logic [1:0] {
    APRR_IDLE = 2'b01,
    APRR_CONV = 2'b10
  } aprr_state_e;

  // read strobes of the host side
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic byte_sel;
  } aprr_rd_s;
endpackage

/* File: hdl/aprr_fifo.sv */
// aprr_fifo: sample fifo between the converter input and the result register
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ns
module aprr_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // aprr_fifo

/* File: test/aprr_host.sv */
// aprr_host: host model giving start strobes and parallel bus reads
// assumes strobes change at the falling clock edge
`timescale 1ns/1ns
module aprr_host (
  input  wire logic                       clk,
  input  wire logic                       busy,
  input  wire logic                       isolate,
  input  wire logic [aprr_pkg::RES_W-1:0] bus_val,
  input  wire logic [aprr_pkg::RES_W-1:0] bus_oe,
  output logic                            conversion_start_n,
  output aprr_pkg::aprr_rd_s              rd
);
  initial begin
    conversion_start_n = 1'b1;
    rd = 3'b110;
  end
  ////////////////////////////////////////////////////////////////
  // start, then count busy cycles with input held off
  task automatic start_conv(input logic again, output int rise, output int high);
    int k;
    rise = 0;
    high = 0;
    k = 0;
    repeat (5) @(negedge clk);
    conversion_start_n = 1'b0;
    while (busy !== 1'b1 && rise < 4) begin
      @(negedge clk);
      rise++;
    end
    while (busy === 1'b1 && k < 100) begin
      if (isolate === 1'b1) high++;
      k++;
      if (k == 4 || k == 24) conversion_start_n = 1'b1;
      if (k == 20 && again) conversion_start_n = 1'b0;
      @(negedge clk);
    end
    conversion_start_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  // one read with strobes {cs_n, rd_n, byte_sel}; undriven lines come back as z
  task automatic read_bus(input logic [2:0] s, output logic [15:0] v);
    rd = s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 16; i++) v[i] = bus_oe[i] ? bus_val[i] : 1'bz;
    rd = 3'h6;
    @(negedge clk);
  endtask
endmodule // aprr_host

/* File: test/tb.sv */
// tb: self-checking bench for aprr_top
// assumes the host model drives strobes and the bench feeds samples
`timescale 1ns/1ns
module tb;
  logic clk, rst, sample_valid, sample_ready, busy, isolate, conversion_start_n;
  logic [15:0] sample_data, bus_val, bus_oe;
  aprr_pkg::aprr_rd_s rd;
  int err_total, total_checks;
  aprr_top dut (.clk(clk), .rst(rst), .conversion_start_n(conversion_start_n), .rd_in(rd),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .busy(busy), .isolate(isolate), .result_bus(bus_val), .result_bus_oe(bus_oe));
  aprr_host host (.clk(clk), .busy(busy), .isolate(isolate), .bus_val(bus_val),
    .bus_oe(bus_oe), .conversion_start_n(conversion_start_n), .rd(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] val(input int n);
    return (n == 1) ? 16'h0000 : 16'h7fff - 16'(n) * 16'h0813;
  endfunction
  ////////////////////////////////////////////////////////////////
  // fill sample fifo until it refuses
  task automatic t_fill();
    int n;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      sample_valid = sample_ready;
      sample_data = val(n);
      if (sample_ready) n++;
    end
    @(negedge clk);
    sample_valid = 1'b0;
    check(16'(n), 16'(aprr_pkg::FIFO_DEPTH));
  endtask
  // one conversion, then word, byte, deselected and repeat reads
  task automatic t_conv(input int n);
    int r, h;
    logic [15:0] v, e;
    e = val(n);
    host.start_conv(n == 0, r, h);
    check(16'(h), 16'(aprr_pkg::CONV_CYCLES));
    check(16'(r <= 2), 16'h0001);
    host.read_bus(3'h0, v);
    check(v, e);
    host.read_bus(3'h1, v);
    check(v, {e[7:0], aprr_pkg::LOW_FILL});
    host.read_bus(3'h4, v);
    check(v, 16'hzzzz);
    host.read_bus(3'h2, v);
    check(v, 16'hzzzz);
    host.read_bus(3'h0, v);
    check(v, e);
  endtask
  // start with nothing sampled is ignored, result held
  task automatic t_empty();
    int r, h;
    logic [15:0] v;
    check({15'h0000, sample_ready}, 16'h0001);
    host.start_conv(1'b0, r, h);
    check(16'(h), 16'h0000);
    host.read_bus(3'h0, v);
    check(v, val(15));
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    err_total++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check({15'h0000, busy}, 16'h0000);
    t_fill();
    for (int i = 0; i < 16; i++) t_conv(i);
    t_empty();
    end_sim();
  end
endmodule // tb
